// *** include/pmr_pkg.sv ***
// Constants and types shared by the power-mode and reset control block.
package pmr_pkg;
    localparam logic [7:0] KEY_NOP      = 8'h00;
    localparam logic [7:0] KEY_IDLE     = 8'h01;
    localparam logic [7:0] KEY_POWERDN  = 8'h02;
    localparam logic [7:0] KEY_NOP3     = 8'h03;
    localparam int         CAUSE_CFD    = 0;
    localparam int         CAUSE_WDT    = 1;
    localparam int         CAUSE_SFW    = 2;
    localparam int         CAUSE_EXT    = 3;
    localparam logic [3:0] CAUSE_RESET  = 4'h0;
    localparam logic [1:0] MODE_RUN     = 2'h0;
    localparam logic [1:0] MODE_IDLE    = 2'h1;
    localparam logic [1:0] MODE_PWRDN   = 2'h2;
    localparam logic       PLL_RESET    = 1'b0;
    localparam int         SWRST_CYCLES = 4;
    localparam logic [2:0] SWRST_LAST   = 3'(SWRST_CYCLES - 1);

    typedef enum logic [4:0] {
        ST_RUN   = 5'b00001,
        ST_DRAIN = 5'b00010,
        ST_IDLE  = 5'b00100,
        ST_PWRDN = 5'b01000,
        ST_SWRST = 5'b10000
    } pm_state_e;
endpackage

// *** rtl/pin_sync.sv ***
// Two-flip-flop synchroniser for one pin level.
`timescale 1ns/1ps
module pin_sync
    import pmr_pkg::*;
(
    // Clock.
    input  wire logic clk_i,
    // Level in and synchronised level out.
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;
    logic next_meta;
    logic next_q;

    // The chain carries no reset, so the pin level is already settled when reset is released.
    always_comb begin
        next_meta = d_i;
        next_q    = meta;
    end

    always_ff @(posedge clk_i) begin
        meta <= next_meta;
        q_o  <= next_q;
    end
endmodule // pin_sync

// *** rtl/power_mode_reset_control.sv ***
// Power-mode and reset control: key decode, prefetch drain, reset cause and PLL latch.
`timescale 1ns/1ps
module power_mode_reset_control
    import pmr_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // Instruction from the core.
    input  wire logic       idle_powerdown_instruction_i,
    input  wire logic [7:0] key_i,
    // Bus controller status.
    input  wire logic       prefetch_busy_i,
    // Wake request ending idle or powerdown.
    input  wire logic       wake_i,
    // Reset causes.
    input  wire logic       power_up_i,
    input  wire logic       clock_fail_event_i,
    input  wire logic       watchdog_event_i,
    input  wire logic       external_pin_event_i,
    // PLL enable pin.
    input  wire logic       pll_enable_pin_i,
    // Status outputs.
    output logic            cpu_stop_o,
    output logic            clocks_stop_o,
    output logic [1:0]      power_mode_o,
    output logic            soft_reset_o,
    output logic [3:0]      reset_cause_register_o,
    output logic            pll_enable_o
);
    pm_state_e  state;
    pm_state_e  next_state;
    logic [1:0] target;
    logic [1:0] next_target;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic       next_cpu_stop;
    logic       next_clocks_stop;
    logic [1:0] next_power_mode;
    logic       next_soft_reset;
    logic [3:0] next_cause;
    logic       pll_sync;
    logic       pll_latched_done;
    logic       next_pll_latched_done;
    logic       next_pll_enable;

    function automatic logic [1:0] decode_key(input logic [7:0] k);
        if (k == KEY_IDLE) begin
            decode_key = MODE_IDLE;
        end else if (k == KEY_POWERDN) begin
            decode_key = MODE_PWRDN;
        end else begin
            decode_key = MODE_RUN;
        end
    endfunction

    function automatic logic key_illegal(input logic [7:0] k);
        key_illegal = (k > KEY_NOP3);
    endfunction

    pin_sync u_pll_sync (
        .clk_i  (clk_i),
        .d_i    (pll_enable_pin_i),
        .q_o    (pll_sync)
    );

    always_comb begin
        next_state  = state;
        next_target = target;
        next_cnt    = cnt;
        case (state)
            ST_RUN: begin
                if (idle_powerdown_instruction_i) begin
                    if (key_illegal(key_i)) begin
                        next_target = MODE_RUN;
                        next_state  = ST_DRAIN;
                    end else if (decode_key(key_i) != MODE_RUN) begin
                        next_target = decode_key(key_i);
                        next_state  = ST_DRAIN;
                    end
                    // Keys 0 and 3 fall through and stay running.
                end
            end
            ST_DRAIN: begin
                if (!prefetch_busy_i) begin
                    if (target == MODE_IDLE) begin
                        next_state = ST_IDLE;
                    end else if (target == MODE_PWRDN) begin
                        next_state = ST_PWRDN;
                    end else begin
                        next_state = ST_SWRST;
                        next_cnt   = 3'h0;
                    end
                end
            end
            ST_IDLE, ST_PWRDN: begin
                if (wake_i) begin
                    next_state = ST_RUN;
                end
            end
            ST_SWRST: begin
                if (cnt == SWRST_LAST) begin
                    next_state = ST_RUN;
                end else begin
                    next_cnt = cnt + 3'h1;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
        if (!rstn_i) begin
            next_state  = ST_RUN;
            next_target = MODE_RUN;
            next_cnt    = 3'h0;
        end
    end

    always_comb begin
        next_cpu_stop    = (next_state == ST_IDLE) || (next_state == ST_PWRDN) || (next_state == ST_SWRST);
        next_clocks_stop = (next_state == ST_PWRDN);
        next_soft_reset  = (next_state == ST_SWRST);
        case (next_state)
            ST_IDLE:  next_power_mode = MODE_IDLE;
            ST_PWRDN: next_power_mode = MODE_PWRDN;
            default:  next_power_mode = MODE_RUN;
        endcase
    end

    always_comb begin
        next_cause = reset_cause_register_o;
        if (power_up_i) begin
            next_cause = CAUSE_RESET;
        end else begin
            if (clock_fail_event_i) begin
                next_cause[CAUSE_CFD] = 1'b1;
            end
            if (watchdog_event_i) begin
                next_cause[CAUSE_WDT] = 1'b1;
            end
            if (state == ST_DRAIN && !prefetch_busy_i && target == MODE_RUN) begin
                next_cause[CAUSE_SFW] = 1'b1;
            end
            if (external_pin_event_i) begin
                next_cause[CAUSE_EXT] = 1'b1;
            end
        end
    end

    always_comb begin
        next_pll_latched_done = rstn_i ? 1'b1 : 1'b0;
        next_pll_enable       = pll_enable_o;
        if (!rstn_i) begin
            next_pll_enable = PLL_RESET;
        end else if (!pll_latched_done) begin
            next_pll_enable = pll_sync;
        end
    end

    always_ff @(posedge clk_i) begin
        state                  <= next_state;
        target                 <= next_target;
        cnt                    <= next_cnt;
        cpu_stop_o             <= next_cpu_stop;
        clocks_stop_o          <= next_clocks_stop;
        power_mode_o           <= next_power_mode;
        soft_reset_o           <= next_soft_reset;
        reset_cause_register_o <= next_cause;
        pll_latched_done       <= next_pll_latched_done;
        pll_enable_o           <= next_pll_enable;
    end

    // Checks.
    sequence s_drain_done;
        state == ST_DRAIN && !prefetch_busy_i;
    endsequence

    property p_idle;
        @(posedge clk_i) disable iff (!rstn_i)
        (state == ST_RUN && idle_powerdown_instruction_i && key_i == KEY_IDLE) |=> state == ST_DRAIN && target == MODE_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("idle key not taken");

    property p_pwrdn;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_drain_done ##0 (target == MODE_PWRDN)) |=> clocks_stop_o && power_mode_o == MODE_PWRDN;
    endproperty
    a_pwrdn: assert property (p_pwrdn) else $error("powerdown not entered");

    property p_illegal;
        @(posedge clk_i) disable iff (!rstn_i)
        (state == ST_RUN && idle_powerdown_instruction_i && key_i > KEY_NOP3) ##1 (!prefetch_busy_i)
            |=> soft_reset_o;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal key did not reset");

    property p_nop;
        @(posedge clk_i) disable iff (!rstn_i)
        (state == ST_RUN && idle_powerdown_instruction_i && (key_i == KEY_NOP3 || key_i == KEY_NOP))
            |=> state == ST_RUN && !soft_reset_o;
    endproperty
    a_nop: assert property (p_nop) else $error("key 0 or 3 changed mode");

    property p_drain;
        @(posedge clk_i) disable iff (!rstn_i)
        (state == ST_DRAIN && prefetch_busy_i) |=> !cpu_stop_o;
    endproperty
    a_drain: assert property (p_drain) else $error("stopped during prefetch");

    property p_powerup;
        @(posedge clk_i) disable iff (!rstn_i)
        power_up_i |=> reset_cause_register_o == CAUSE_RESET;
    endproperty
    a_powerup: assert property (p_powerup) else $error("cause flags not cleared");

    property p_pll;
        @(posedge clk_i) disable iff (!rstn_i)
        (pll_latched_done && $past(pll_latched_done)) |-> $stable(pll_enable_o);
    endproperty
    a_pll: assert property (p_pll) else $error("pll state changed in operation");

    property p_swrst_len;
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(soft_reset_o) |-> soft_reset_o [*4] ##1 !soft_reset_o;
    endproperty
    a_swrst_len: assert property (p_swrst_len) else $error("soft reset length wrong");
endmodule // power_mode_reset_control

// *** verification/tb_power_mode_reset_control.sv ***
// Self-checking testbench for the power-mode and reset control block.
`timescale 1ns/1ps
module tb_power_mode_reset_control
    import pmr_pkg::*;
;
    logic       clk_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic       instr = 1'b0;
    logic [7:0] key = 8'h00;
    logic       busy = 1'b0;
    logic       wake = 1'b0;
    logic       pwr_up = 1'b0;
    logic       cf_ev = 1'b0;
    logic       wd_ev = 1'b0;
    logic       ext_ev = 1'b0;
    logic       pll_pin = 1'b1;
    logic       cpu_stop, clk_stop, soft_rst, pll_en;
    logic [1:0] mode;
    logic [3:0] cause;
    int         errors = 0;
    int         comparisons = 0;

    always #20 clk_i = ~clk_i;

    power_mode_reset_control u_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .idle_powerdown_instruction_i(instr), .key_i(key),
        .prefetch_busy_i(busy), .wake_i(wake), .power_up_i(pwr_up), .clock_fail_event_i(cf_ev),
        .watchdog_event_i(wd_ev), .external_pin_event_i(ext_ev), .pll_enable_pin_i(pll_pin),
        .cpu_stop_o(cpu_stop), .clocks_stop_o(clk_stop), .power_mode_o(mode), .soft_reset_o(soft_rst),
        .reset_cause_register_o(cause), .pll_enable_o(pll_en));

    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic issue(input logic [7:0] k);
        @(posedge clk_i);
        instr <= 1'b1;
        key <= k;
        @(posedge clk_i);
        instr <= 1'b0;
    endtask

    task automatic pulse(input logic [3:0] m, input logic pu);
        @(posedge clk_i);
        cf_ev <= m[CAUSE_CFD];
        wd_ev <= m[CAUSE_WDT];
        ext_ev <= m[CAUSE_EXT];
        pwr_up <= pu;
        @(posedge clk_i);
        {cf_ev, wd_ev, ext_ev, pwr_up} <= 4'h0;
        @(negedge clk_i);
    endtask

    // Raises wake for one cycle to bring the block back to run.
    task automatic wake_up();
        @(posedge clk_i);
        wake <= 1'b1;
        @(posedge clk_i);
        wake <= 1'b0;
    endtask

    // Enters a stop mode with the bus idle, checks the status, then wakes the block.
    task automatic stop_run(input logic [7:0] k, input logic [1:0] m, input logic cs);
        issue(k);
        for (int i = 0; i < 8 && cpu_stop !== 1'b1; i++) @(negedge clk_i);
        chk("cpu_stop", 4'h1, 4'(cpu_stop));
        chk("power_mode", 4'(m), 4'(mode));
        chk("clocks_stop", 4'(cs), 4'(clk_stop));
        wake_up();
        tick(2);
        @(negedge clk_i);
        chk("status after wake", 4'h0, {soft_rst, cpu_stop, mode});
        chk("clocks_stop after wake", 4'h0, 4'(clk_stop));
    endtask

    task automatic test_cause();
        pulse(4'h0, 1'b1);
        chk("cause cleared", CAUSE_RESET, cause);
        pulse(4'h1, 1'b0);
        pulse(4'h2, 1'b0);
        pulse(4'h8, 1'b0);
        chk("cause set", 4'hb, cause);
        pulse(4'hb, 1'b1);
        chk("cause power-up wins", CAUSE_RESET, cause);
        $display("test cause done");
    endtask

    task automatic test_nop();
        logic [7:0] keys [2] = '{KEY_NOP, KEY_NOP3};
        foreach (keys[j]) begin
            issue(keys[j]);
            repeat (8) begin
                @(negedge clk_i);
                chk("status nop", 4'h0, {soft_rst, cpu_stop, mode});
            end
            chk("cause nop", CAUSE_RESET, cause);
        end
        $display("test nop done");
    endtask

    task automatic test_stop();
        @(posedge clk_i);
        busy <= 1'b1;
        issue(KEY_IDLE);
        repeat (5) begin
            @(negedge clk_i);
            chk("cpu_stop while busy", 4'h0, 4'(cpu_stop));
        end
        @(posedge clk_i);
        busy <= 1'b0;
        for (int i = 0; i < 8 && cpu_stop !== 1'b1; i++) @(negedge clk_i);
        chk("cpu_stop after drain", 4'h1, 4'(cpu_stop));
        chk("idle mode", 4'(MODE_IDLE), 4'(mode));
        wake_up();
        stop_run(KEY_IDLE, MODE_IDLE, 1'b0);
        stop_run(KEY_POWERDN, MODE_PWRDN, 1'b1);
        $display("test stop done");
    endtask

    task automatic test_soft();
        int n;
        logic [7:0] keys [2] = '{8'h04, 8'hff};
        foreach (keys[j]) begin
            pulse(4'h0, 1'b1);
            n = 0;
            issue(keys[j]);
            for (int i = 0; i < 14; i++) begin
                @(negedge clk_i);
                n += int'(soft_rst === 1'b1);
            end
            chk("soft reset cycles", 4'(SWRST_CYCLES), 4'(n));
            chk("cause software", 4'h1 << CAUSE_SFW, cause);
        end
        $display("test soft done");
    endtask

    task automatic test_pll();
        chk("pll latched high", 4'h1, 4'(pll_en));
        @(posedge clk_i);
        pll_pin <= 1'b0;
        tick(5);
        @(negedge clk_i);
        chk("pll ignores pin", 4'h1, 4'(pll_en));
        issue(KEY_POWERDN);
        tick(3);
        @(negedge clk_i);
        chk("powerdown before reset", 4'h1, 4'(clk_stop));
        @(posedge clk_i);
        rstn_i <= 1'b0;
        tick(4);
        @(negedge clk_i);
        chk("status in reset", 4'h0, {soft_rst, cpu_stop, mode});
        chk("clocks_stop in reset", 4'h0, 4'(clk_stop));
        chk("cause kept", 4'h1 << CAUSE_SFW, cause);
        @(posedge clk_i);
        rstn_i <= 1'b1;
        tick(2);
        pll_pin <= 1'b1;
        tick(5);
        @(negedge clk_i);
        chk("pll latched low", 4'h0, 4'(pll_en));
        $display("test pll done");
    endtask

    initial begin
        tick(20);
        rstn_i <= 1'b1;
        tick(2);
        test_cause();
        test_nop();
        test_stop();
        test_soft();
        test_pll();
        tally_and_finish();
    end

    initial begin
        tick(3000);
        errors++;
        tally_and_finish();
    end
endmodule // tb_power_mode_reset_control
